// *** core/fifo_flag_core.sv ***
// Functional notes
// - full flag releases on the edge after a read frees space.
// - empty flag releases on the edge after a write stores a word.
// - both ports keep clocking during reset without harm.
// - after reset data reads low; enable low drives, high floats.
// - first word reachable one clock after the write into empty.
// - first word appears on the read edge after empty releases.
// - almost-empty goes low once fewer than n words remain.
// - almost-full goes low once depth minus m words are stored.
// - sync mode defers almost-empty change to the next edge.
// - sync mode defers almost-full change to the next edge.
// - replay rewinds reads; flags valid after recovery time.
// - sync almost flags refresh only on an edge after recovery.
// - pulse expansion outputs on access to last physical word.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module fifo_flag_core
   import fifo_flag_pkg::*;
#(
   parameter int DEPTH = fifo_flag_pkg::DEPTH_DEF
) (
   input  wire logic                            ref_clk,
   input  wire logic                            rst_n,
   input  wire fifo_flag_pkg::apb_req_s         apb_req,
   output fifo_flag_pkg::apb_rsp_s              apb_rsp,
   input  wire logic                            wr_en,
   input  wire logic [fifo_flag_pkg::DATA_W-1:0] wr_data,
   input  wire logic                            rd_en,
   input  wire logic                            out_en_n,
   output logic      [fifo_flag_pkg::DATA_W-1:0] rd_data,
   output logic                                 rd_data_oe,
   input  wire logic                            sync_flag_select,
   input  wire logic                            replay_request,
   output logic                                 full_flag_n,
   output logic                                 empty_flag_n,
   output logic                                 almost_empty_flag_n,
   output logic                                 almost_full_flag_n,
   output logic                                 write_exp_out,
   output logic                                 read_exp_out,
   output logic                                 irq
);
   import fifo_flag_pkg::*;

   localparam int            AW   = $clog2(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   typedef struct packed {
      logic [AW:0]       wptr;
      logic [AW:0]       rptr;
      flags_s            flags;
      logic [OFS_W-1:0]  ae_ofs;
      logic [OFS_W-1:0]  af_ofs;
      logic [RTR_W-1:0]  rtr_cnt;
      logic              replay_q;
      logic              wr_exp;
      logic              rd_exp;
      logic [31:0]       prdata;
   } core_state_s;

   core_state_s       cur;
   core_state_s       next;
   logic              wr_ok;
   logic              rd_ok;
   logic              replay_rise;
   logic              recovering;
   logic [AW:0]       cnt_now;
   logic [AW:0]       cnt_next;
   logic              bus_wr;
   logic              mapped;
   logic [EV_W-1:0]   events;
   logic [EV_W-1:0]   irq_status;
   logic [EV_W-1:0]   irq_mask;

   // a < b on 32-bit extended operands, shared by both almost flags
   function automatic logic below(input logic [31:0] a, input logic [31:0] b);
      below = (a < b);
   endfunction : below

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] r);
      hit = (a == r);
   endfunction : hit

   assign replay_rise = replay_request & ~cur.replay_q;
   assign recovering  = (cur.rtr_cnt != '0);
   assign wr_ok       = wr_en & cur.flags.full_n;
   // reads are held off while the read pointer is being rewound
   assign rd_ok       = rd_en & cur.flags.empty_n & ~recovering & ~replay_rise;
   assign cnt_now     = cur.wptr - cur.rptr;

   assign mapped = hit(apb_req.paddr, AE_OFS_ADDR) | hit(apb_req.paddr, AF_OFS_ADDR)
                 | hit(apb_req.paddr, LEVEL_ADDR)  | hit(apb_req.paddr, IRQ_STAT_ADDR)
                 | hit(apb_req.paddr, IRQ_MASK_ADDR);
   assign bus_wr = apb_req.psel & apb_req.penable & apb_req.pwrite & mapped;

   always_comb begin
      next = cur;
      next.replay_q = replay_request;

      if (wr_ok) begin
         next.wptr = cur.wptr + (AW+1)'(1);
      end
      if (rd_ok) begin
         next.rptr = cur.rptr + (AW+1)'(1);
      end
      if (replay_rise) begin
         // rewind to the first location; valid while the store never wrapped
         next.rptr    = {cur.wptr[AW], {AW{1'b0}}};
         next.rtr_cnt = RTR_W'(REPLAY_RECOVERY_CYC);
      end else if (recovering) begin
         next.rtr_cnt = cur.rtr_cnt - RTR_W'(1);
      end

      cnt_next = next.wptr - next.rptr;

      // full and empty follow the count at the very next edge
      next.flags.full_n  = (32'(cnt_next) != 32'(DEPTH));
      next.flags.empty_n = (cnt_next != '0);

      if (sync_flag_select) begin
         // free mode: almost flags track the count as soon as it moves
         next.flags.ae_n = ~below(32'(cnt_next), 32'(cur.ae_ofs));
         next.flags.af_n = below(32'(cnt_next),
                                 32'(DEPTH) - 32'(cur.af_ofs));
      end else if (!recovering) begin
         // sync mode: both port edges coincide, so the skew is never met
         // and the change lands one edge later; frozen during recovery
         next.flags.ae_n = ~below(32'(cnt_now), 32'(cur.ae_ofs));
         next.flags.af_n = below(32'(cnt_now),
                                 32'(DEPTH) - 32'(cur.af_ofs));
      end

      next.wr_exp = wr_ok & (cur.wptr[AW-1:0] == LAST);
      next.rd_exp = rd_ok & (cur.rptr[AW-1:0] == LAST);

      if (bus_wr && hit(apb_req.paddr, AE_OFS_ADDR)) begin
         next.ae_ofs = apb_req.pwdata[OFS_W-1:0];
      end
      if (bus_wr && hit(apb_req.paddr, AF_OFS_ADDR)) begin
         next.af_ofs = apb_req.pwdata[OFS_W-1:0];
      end

      // read data is captured in the setup cycle so the access needs no wait
      if (apb_req.psel && !apb_req.penable) begin
         next.prdata = '0;
         unique case (1'b1)
            hit(apb_req.paddr, AE_OFS_ADDR): begin
               next.prdata = 32'(cur.ae_ofs);
            end
            hit(apb_req.paddr, AF_OFS_ADDR): begin
               next.prdata = 32'(cur.af_ofs);
            end
            hit(apb_req.paddr, LEVEL_ADDR): begin
               next.prdata = 32'(cnt_now);
               next.prdata[LVL_FLAG_LSB +: 4] = cur.flags;
            end
            hit(apb_req.paddr, IRQ_STAT_ADDR): begin
               next.prdata = 32'(irq_status);
            end
            hit(apb_req.paddr, IRQ_MASK_ADDR): begin
               next.prdata = 32'(irq_mask);
            end
            default: begin
               next.prdata = '0;
            end
         endcase
      end
   end

   // reset is sampled only through the async clear; clocks may keep running
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur         <= '0;
         cur.flags   <= '{full_n: 1'b1, empty_n: 1'b0, ae_n: 1'b0, af_n: 1'b1};
         cur.ae_ofs  <= AE_OFS_RST;
         cur.af_ofs  <= AF_OFS_RST;
      end else begin
         cur <= next;
      end
   end

   always_comb begin
      events            = '0;
      events[EV_FULL]   = cur.flags.full_n & ~next.flags.full_n;
      events[EV_EMPTY]  = cur.flags.empty_n & ~next.flags.empty_n;
      events[EV_AFULL]  = cur.flags.af_n & ~next.flags.af_n;
      events[EV_AEMPTY] = cur.flags.ae_n & ~next.flags.ae_n;
      events[EV_WR_EXP] = next.wr_exp;
      events[EV_RD_EXP] = next.rd_exp;
      events[EV_WR_REF] = wr_en & ~cur.flags.full_n;
      events[EV_RD_REF] = rd_en & ~rd_ok;
   end

   fifo_store #(
      .DATA_W (DATA_W),
      .DEPTH  (DEPTH),
      .AW     (AW)
   ) u_store (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .we      (wr_ok),
      .waddr   (cur.wptr[AW-1:0]),
      .wdata   (wr_data),
      .re      (rd_ok),
      .raddr   (cur.rptr[AW-1:0]),
      .rdata   (rd_data)
   );

   event_irq #(
      .N (EV_W)
   ) u_irq (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .events  (events),
      .clr_wr  (bus_wr & hit(apb_req.paddr, IRQ_STAT_ADDR)),
      .mask_wr (bus_wr & hit(apb_req.paddr, IRQ_MASK_ADDR)),
      .wdata   (apb_req.pwdata[EV_W-1:0]),
      .status  (irq_status),
      .mask    (irq_mask),
      .irq     (irq)
   );

   assign rd_data_oe          = ~out_en_n;
   assign full_flag_n         = cur.flags.full_n;
   assign empty_flag_n        = cur.flags.empty_n;
   assign almost_empty_flag_n = cur.flags.ae_n;
   assign almost_full_flag_n  = cur.flags.af_n;
   assign write_exp_out       = cur.wr_exp;
   assign read_exp_out        = cur.rd_exp;

   assign apb_rsp.prdata  = cur.prdata;
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~mapped;

endmodule : fifo_flag_core

// *** core/fifo_flag_pkg.sv ***
package fifo_flag_pkg;

   localparam int DATA_W    = 18;
   localparam int DEPTH_DEF = 8192;
   localparam int OFS_W     = 16;
   localparam int ADDR_W    = 12;

   // timing: one clock for both ports
   localparam int CLK_PERIOD_NS       = 50;
   localparam int REPLAY_RECOVERY_NS  = 90;
   localparam int REPLAY_RECOVERY_CYC =
      (REPLAY_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RTR_W = $clog2(REPLAY_RECOVERY_CYC + 1);

   // register byte addresses
   localparam logic [ADDR_W-1:0] AE_OFS_ADDR   = 12'h000;
   localparam logic [ADDR_W-1:0] AF_OFS_ADDR   = 12'h004;
   localparam logic [ADDR_W-1:0] LEVEL_ADDR    = 12'h008;
   localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 12'h00C;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 12'h010;

   localparam logic [OFS_W-1:0] AE_OFS_RST = 16'h007F;
   localparam logic [OFS_W-1:0] AF_OFS_RST = 16'h007F;

   // level register: word count in the low bits, flags from this bit up
   localparam int LVL_FLAG_LSB = 24;

   // event bit positions in status and mask
   localparam int EV_FULL   = 0;
   localparam int EV_EMPTY  = 1;
   localparam int EV_AFULL  = 2;
   localparam int EV_AEMPTY = 3;
   localparam int EV_WR_EXP = 4;
   localparam int EV_RD_EXP = 5;
   localparam int EV_WR_REF = 6;
   localparam int EV_RD_REF = 7;
   localparam int EV_W      = 8;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_s;

   typedef struct packed {
      logic full_n;
      logic empty_n;
      logic ae_n;
      logic af_n;
   } flags_s;

endpackage : fifo_flag_pkg

// *** core/fifo_store.sv ***
`timescale 1ns/10ps
module fifo_store #(
   parameter int DATA_W = 18,
   parameter int DEPTH  = 8192,
   parameter int AW     = $clog2(DEPTH)
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              we,
   input  wire logic [AW-1:0]     waddr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              re,
   input  wire logic [AW-1:0]     raddr,
   output logic      [DATA_W-1:0] rdata
);
   typedef struct packed {
      logic [DATA_W-1:0] q;
   } store_state_s;

   logic [DATA_W-1:0] ram [DEPTH];
   store_state_s      cur;
   store_state_s      next;

   // the array has no reset; only the output word does
   always_ff @(posedge ref_clk) begin
      if (we) begin
         ram[waddr] <= wdata;
      end
   end

   always_comb begin
      next = cur;
      if (re) begin
         next.q = ram[raddr];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next;
      end
   end

   assign rdata = cur.q;

endmodule : fifo_store

// *** core/event_irq.sv ***
`timescale 1ns/10ps
module event_irq #(
   parameter int N = 8
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic [N-1:0] events,
   input  wire logic         clr_wr,
   input  wire logic         mask_wr,
   input  wire logic [N-1:0] wdata,
   output logic      [N-1:0] status,
   output logic      [N-1:0] mask,
   output logic              irq
);
   typedef struct packed {
      logic [N-1:0] status;
      logic [N-1:0] mask;
      logic         irq;
   } irq_state_s;

   irq_state_s cur;
   irq_state_s next;

   always_comb begin
      next = cur;
      // a new event in the clearing cycle survives the clear
      next.status = (cur.status & ~(clr_wr ? wdata : '0)) | events;
      if (mask_wr) begin
         next.mask = wdata;
      end
      next.irq = |(next.status & next.mask);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next;
      end
   end

   assign status = cur.status;
   assign mask   = cur.mask;
   assign irq    = cur.irq;

endmodule : event_irq

// *** bench/fifo_host.sv ***
`timescale 1ns/10ps
module fifo_host
   import fifo_flag_pkg::*;
(
   input  wire logic                             ref_clk,
   input  wire logic                             rst_n,
   input  wire logic                             wr_go,
   input  wire logic                             rd_go,
   input  wire logic                             full_flag_n,
   output logic                                  wr_en,
   output logic      [fifo_flag_pkg::DATA_W-1:0] wr_data,
   output logic                                  rd_en
);
   // the word only moves on once the fifo took it, so a refused word is offered again
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_en   <= 1'b0;
         rd_en   <= 1'b0;
         wr_data <= '0;
      end else begin
         wr_en <= wr_go;
         rd_en <= rd_go;
         if (wr_en && full_flag_n) begin
            wr_data <= wr_data + DATA_W'(1);
         end
      end
   end
endmodule : fifo_host

// *** bench/fifo_flag_chk.sv ***
`timescale 1ns/10ps
module fifo_flag_chk
   import fifo_flag_pkg::*;
#(
   parameter int DEPTH = 16
) (
   input wire logic                             ref_clk,
   input wire logic                             rst_n,
   input wire fifo_flag_pkg::apb_req_s          apb_req,
   input wire fifo_flag_pkg::apb_rsp_s          apb_rsp,
   input wire logic                             wr_en,
   input wire logic                             rd_en,
   input wire logic                             out_en_n,
   input wire logic [fifo_flag_pkg::DATA_W-1:0] rd_data,
   input wire logic                             rd_data_oe,
   input wire logic                             sync_flag_select,
   input wire logic                             replay_request,
   input wire logic                             full_flag_n,
   input wire logic                             empty_flag_n,
   input wire logic                             almost_empty_flag_n,
   input wire logic                             almost_full_flag_n,
   input wire logic                             write_exp_out,
   input wire logic                             read_exp_out
);
   localparam int PW = $clog2(DEPTH);
   logic             rp_q;
   logic [RTR_W-1:0] rec;
   logic [16:0]      cnt;
   logic [16:0]      wtot;
   logic [15:0]      ae_ofs;
   logic [15:0]      af_ofs;
   logic [PW-1:0]    wptr;
   logic [PW-1:0]    rptr;
   wire rise   = replay_request & ~rp_q;
   wire wr_ok  = wr_en & full_flag_n;
   wire rd_ok  = rd_en & empty_flag_n & ~rise & (rec == '0);
   wire ap_wr  = apb_req.psel & apb_req.penable & apb_req.pwrite;
   wire ae_hit = cnt >= 17'(ae_ofs);
   // an offset beyond the depth is a threshold that no level can reach, so the flag stays high
   wire af_hit = int'(af_ofs) <= DEPTH && int'(cnt) >= DEPTH - int'(af_ofs);
   // replay assumes no wrap, so the word count restarts from all writes since reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rp_q   <= 1'b0;
         rec    <= '0;
         cnt    <= '0;
         wtot   <= '0;
         wptr   <= '0;
         rptr   <= '0;
         ae_ofs <= AE_OFS_RST;
         af_ofs <= AF_OFS_RST;
      end else begin
         rp_q <= replay_request;
         rec  <= rise ? RTR_W'(REPLAY_RECOVERY_CYC) : rec - RTR_W'(rec != '0);
         wtot <= wtot + 17'(wr_ok);
         wptr <= wptr + PW'(wr_ok);
         rptr <= rise ? '0 : rptr + PW'(rd_ok);
         cnt  <= rise ? wtot + 17'(wr_ok) : cnt + 17'(wr_ok) - 17'(rd_ok);
         if (ap_wr && apb_req.paddr == AE_OFS_ADDR) ae_ofs <= apb_req.pwdata[15:0];
         if (ap_wr && apb_req.paddr == AF_OFS_ADDR) af_ofs <= apb_req.pwdata[15:0];
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_last_wr;
      wr_ok && int'(wptr) == DEPTH - 1;
   endsequence
   sequence s_last_rd;
      rd_ok && int'(rptr) == DEPTH - 1;
   endsequence
   AST_OE_PIN: assert property (rd_data_oe == !out_en_n)
      else $error("data enable differs from out_en_n");
   AST_RST_OUT: assert property (!$past(rst_n) |-> rd_data == '0 && !empty_flag_n)
      else $error("outputs wrong after reset");
   AST_EMPTY_REL: assert property (wr_ok && !empty_flag_n |=> empty_flag_n)
      else $error("empty flag not released after write");
   AST_FULL_REL: assert property (rd_ok && !full_flag_n |=> full_flag_n)
      else $error("full flag not released after read");
   AST_LEVEL: assert property (rec == '0 |-> full_flag_n == (int'(cnt) != DEPTH)
      && empty_flag_n == (cnt != '0)) else $error("full or empty flag wrong");
   AST_AE_IMM: assert property (sync_flag_select && $past(sync_flag_select)
      && $stable(ae_ofs) && rec == '0 |-> almost_empty_flag_n == ae_hit)
      else $error("almost empty flag wrong");
   AST_AE_SYNC: assert property (!sync_flag_select && !$past(sync_flag_select)
      && $stable(ae_ofs) && rec == '0 && $past(rec) == '0
      |-> almost_empty_flag_n == $past(ae_hit)) else $error("sync almost empty flag wrong");
   AST_AF_IMM: assert property (sync_flag_select && $past(sync_flag_select)
      && $stable(af_ofs) && rec == '0 |-> almost_full_flag_n == !af_hit)
      else $error("almost full flag wrong");
   AST_AF_SYNC: assert property (!sync_flag_select && !$past(sync_flag_select)
      && $stable(af_ofs) && rec == '0 && $past(rec) == '0
      |-> almost_full_flag_n == !$past(af_hit)) else $error("sync almost full flag wrong");
   AST_WR_EXP: assert property (s_last_wr |=> write_exp_out)
      else $error("no write expansion pulse");
   AST_RD_EXP: assert property (s_last_rd |=> read_exp_out)
      else $error("no read expansion pulse");
   AST_SLVERR: assert property (apb_req.psel && apb_req.penable && apb_req.paddr > IRQ_MASK_ADDR
      |-> apb_rsp.pslverr && apb_rsp.pready) else $error("unmapped access not refused");
endmodule : fifo_flag_chk

// *** bench/tb.sv ***
`timescale 1ns/10ps
module tb;
   import fifo_flag_pkg::*;
   localparam int DEPTH = 16;
   logic ref_clk = 0, rst_n = 0, wr_go = 0, rd_go = 0, out_en_n = 0;
   logic sync_flag_select = 1, replay_request = 0;
   logic wr_en, rd_en, rd_data_oe, full_flag_n, empty_flag_n, ae_n, af_n, wx, rx, irq, e;
   logic [DATA_W-1:0] wr_data, rd_data;
   logic [31:0]       q;
   apb_req_s          req = '0;
   apb_rsp_s          rsp;
   int                bad_count = 0, num_checks = 0, rd_idx = 0, n;
   always #25 ref_clk = ~ref_clk;
   fifo_flag_core #(.DEPTH(DEPTH)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .apb_req(req),
      .apb_rsp(rsp), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .out_en_n(out_en_n),
      .rd_data(rd_data), .rd_data_oe(rd_data_oe), .sync_flag_select(sync_flag_select),
      .replay_request(replay_request), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
      .almost_empty_flag_n(ae_n), .almost_full_flag_n(af_n), .write_exp_out(wx),
      .read_exp_out(rx), .irq(irq));
   fifo_host host (.ref_clk(ref_clk), .rst_n(rst_n), .wr_go(wr_go), .rd_go(rd_go),
      .full_flag_n(full_flag_n), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en));
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
      num_checks++;
      if (got !== x) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, x, got);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask : cyc
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge ref_clk);
      req.penable <= 1'b1;
      do @(posedge ref_clk); while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
   endtask : apb
   task automatic rd_reg(input string nm, input logic [11:0] a, input logic [31:0] m,
                         input logic [31:0] x);
      apb(1'b0, a, '0);
      chk(nm, x, q & m);
   endtask : rd_reg
   task automatic do_reset;
      rst_n <= 1'b0;
      cyc(3);
      rst_n <= 1'b1;
      rd_idx = 0;
   endtask : do_reset
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   // each accepted read must bring the next word in write order
   always @(posedge ref_clk) begin
      if (rst_n && rd_en && empty_flag_n) begin
         #1;
         chk("rd_data", 32'(rd_idx[17:0]), rd_data);
         rd_idx++;
      end
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      bad_count++;
      stop_test;
   end
   initial begin
      do_reset;
      cyc(1);
      chk("rd_data", '0, rd_data);
      chk("data enable", 1, rd_data_oe);
      out_en_n <= 1'b1;
      cyc(1);
      chk("data enable", 0, rd_data_oe);
      out_en_n <= 1'b0;
      rd_reg("ae offset", AE_OFS_ADDR, '1, 32'(AE_OFS_RST));
      rd_reg("af offset", AF_OFS_ADDR, '1, 32'(AF_OFS_RST));
      rd_reg("irq mask", IRQ_MASK_ADDR, '1, 0);
      rd_reg("level", LEVEL_ADDR, '1, 32'h0900_0000);
      apb(1'b1, 12'h020, 32'h1234);
      chk("error response", 1, e);
      rd_reg("unmapped", 12'h020, '1, 0);
      apb(1'b1, AE_OFS_ADDR, 3);
      apb(1'b1, AF_OFS_ADDR, 3);
      apb(1'b1, IRQ_MASK_ADDR, 32'h1 << EV_FULL);
      rd_reg("af offset", AF_OFS_ADDR, '1, 3);
      wr_go <= 1'b1;
      for (n = 0; n < 40 && full_flag_n !== 1'b0; n++) cyc(1);
      chk("full flag", 0, full_flag_n);
      cyc(2);
      wr_go <= 1'b0;
      cyc(2);
      rd_reg("level", LEVEL_ADDR, '1, 32'h0600_0010);
      chk("irq", 1, irq);
      rd_reg("status", IRQ_STAT_ADDR, 32'h55, 32'h55);
      apb(1'b1, IRQ_STAT_ADDR, 32'hFF);
      cyc(2);
      chk("irq", 0, irq);
      sync_flag_select <= 1'b0;
      apb(1'b1, IRQ_MASK_ADDR, 32'h1 << EV_EMPTY);
      rd_go <= 1'b1;
      for (n = 0; n < 40 && empty_flag_n !== 1'b0; n++) cyc(1);
      chk("words read", DEPTH, rd_idx);
      cyc(3);
      rd_go <= 1'b0;
      cyc(2);
      rd_reg("status", IRQ_STAT_ADDR, 32'hAA, 32'hAA);
      chk("irq", 1, irq);
      rd_reg("level", LEVEL_ADDR, '1, 32'h0900_0000);
      rd_go <= 1'b1;
      wr_go <= 1'b1;
      cyc(1);
      wr_go <= 1'b0;
      for (n = 0; n < 4 && rd_idx != DEPTH + 1; n++) cyc(1);
      #2;
      chk("first word", DEPTH + 1, rd_idx);
      @(posedge ref_clk);
      rd_go <= 1'b0;
      cyc(1);
      // clocks keep running through this second reset
      do_reset;
      cyc(1);
      chk("empty flag", 0, empty_flag_n);
      wr_go <= 1'b1;
      cyc(5);
      wr_go <= 1'b0;
      rd_go <= 1'b1;
      cyc(3);
      rd_go <= 1'b0;
      cyc(3);
      replay_request <= 1'b1;
      rd_idx = 0;
      cyc(2);
      replay_request <= 1'b0;
      cyc(4);
      rd_go <= 1'b1;
      for (n = 0; n < 20 && empty_flag_n !== 1'b0; n++) cyc(1);
      chk("replayed words", 5, rd_idx);
      rd_go <= 1'b0;
      cyc(2);
      stop_test;
   end
endmodule : tb
bind fifo_flag_core fifo_flag_chk #(.DEPTH(DEPTH)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .wr_en(wr_en), .rd_en(rd_en), .out_en_n(out_en_n),
   .rd_data(rd_data), .rd_data_oe(rd_data_oe), .sync_flag_select(sync_flag_select),
   .replay_request(replay_request), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
   .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
   .write_exp_out(write_exp_out), .read_exp_out(read_exp_out));
